// ==== common/ps_pkg.sv ====
// Purpose: shared constants and types of the program sequencer
// Assumes: core clock is the system clock, one period per system clock
// Notes: offsets are data memory addresses of the special registers
package ps_pkg;
  localparam int PC_W = 11;
  localparam int PM_W = 14;
  localparam int DATA_W = 8;
  localparam int REG_AW = 8;
  localparam int STACK_DEPTH = 4;
  localparam int NUM_INT = 4;
  localparam int PHASE_W = 2;
  localparam logic [PHASE_W-1:0] LAST_PHASE = 2'h3;
  localparam int SST_PERIODS = 1024;
  localparam int CLK_PER_SYS = 1;
  localparam int SST_CYCLES = SST_PERIODS * CLK_PER_SYS;
  localparam int SST_W = 11;
  localparam logic [REG_AW-1:0] PCL_OFS = 8'h06;
  localparam logic [REG_AW-1:0] TABLE_POINTER_OFS = 8'h07;
  localparam logic [REG_AW-1:0] TABLE_HIGH_BYTE_OFS = 8'h08;
  localparam logic [DATA_W-1:0] TABLE_POINTER_RST = 8'h00;
  localparam logic [DATA_W-1:0] TABLE_HIGH_BYTE_RST = 8'h00;
  localparam logic [PC_W-1:0] RESET_VEC = 11'h000;
  localparam logic [PC_W-1:0] VEC_EXT = 11'h004;
  localparam logic [PC_W-1:0] VEC_TMR0 = 11'h008;
  localparam logic [PC_W-1:0] VEC_TMR1 = 11'h00c;
  localparam logic [PC_W-1:0] VEC_ADC = 11'h010;
  localparam logic [NUM_INT*PC_W-1:0] INT_VECS =
    {VEC_ADC, VEC_TMR1, VEC_TMR0, VEC_EXT};
  localparam logic [2:0] LAST_PAGE = 3'h7;
  localparam int PAGE_LSB = 8;

  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_SKIP = 3'b001,
    CMD_JUMP = 3'b010,
    CMD_CALL = 3'b011,
    CMD_RET = 3'b100,
    CMD_RETURN_FROM_INTERRUPT = 3'b101,
    CMD_TBL_CUR = 3'b110,
    CMD_TBL_LAST = 3'b111
  } ps_cmd_type;

  typedef enum logic [1:0] {
    PWR_START = 2'b00,
    PWR_RUN = 2'b01,
    PWR_HALT = 2'b10
  } ps_pwr_type;
endpackage

// ==== common/ps_core_if.sv ====
// Purpose: links sequencer, timing and return stack
// Assumes: one clock domain
// Notes: no clocking block
`timescale 1ns/1ps
interface ps_core_if;
  logic [ps_pkg::PHASE_W-1:0] phase;
  logic cyc_end;
  logic running;
  logic halt_req;
  logic push;
  logic pop;
  logic [ps_pkg::PC_W-1:0] push_addr;
  logic [ps_pkg::PC_W-1:0] top_addr;
  logic full;
  logic empty;
  modport seq (input phase, cyc_end, running, top_addr, full, empty,
    output halt_req, push, pop, push_addr);
  modport timing (input halt_req, output phase, cyc_end, running);
  modport stack (input push, pop, push_addr, output top_addr, full, empty);
endinterface

// ==== rtl/ps_return_stack.sv ====
// Purpose: hardware return stack, not visible to software
// Assumes: push and pop never in the same cycle
// Notes: a push when full overwrites the oldest entry
`timescale 1ns/1ps
module ps_return_stack #(
  parameter int DEPTH = ps_pkg::STACK_DEPTH
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // sequencer side
  ps_core_if.stack stk
);
  localparam int IW = $clog2(DEPTH);
  localparam logic [IW:0] FULL_CNT = (IW+1)'(DEPTH);

  logic [ps_pkg::PC_W-1:0] mem_r [DEPTH];
  logic [IW-1:0] wr_r;
  logic [IW:0] cnt_r;
  logic [IW-1:0] top_idx;

  generate
    if (DEPTH < 2 || (1 << IW) != DEPTH) begin : g_bad_depth
      $error("stack depth must be a power of two of at least two");
    end
  endgenerate

  assign top_idx = wr_r - 1'b1;
  assign stk.top_addr = mem_r[top_idx];
  assign stk.full = (cnt_r == FULL_CNT);
  assign stk.empty = (cnt_r == '0);

  always_ff @(posedge core_clk_in) begin
    if (stk.push) begin
      mem_r[wr_r] <= stk.push_addr;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_r <= '0;
      cnt_r <= '0;
    end else if (stk.push && !stk.pop) begin
      wr_r <= wr_r + 1'b1;
      if (cnt_r != FULL_CNT) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end else if (stk.pop && !stk.push && cnt_r != '0) begin
      wr_r <= wr_r - 1'b1;
      cnt_r <= cnt_r - 1'b1;
    end
  end

  a_stack_push_top: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) stk.push && !stk.pop
    |=> stk.top_addr == $past(stk.push_addr) && !stk.empty)
    else $error("pushed address not on top");
  a_stack_full_keep: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) stk.push && stk.full |=> stk.full)
    else $error("overflowing push lost fullness");
  a_stack_pop_count: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) stk.pop && !stk.push && !stk.empty
    |=> cnt_r == $past(cnt_r) - 1'b1)
    else $error("pop did not lower the index");
endmodule

// ==== rtl/ps_phase_gen.sv ====
// Purpose: four-phase instruction timing and start-up delay
// Assumes: wake_in is a level from the wake-up logic
// Notes: phases hold at zero while not running
`timescale 1ns/1ps
module ps_phase_gen (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // wake-up from halt
  input wire logic wake_in,
  // sequencer side
  ps_core_if.timing tim
);
  localparam logic [ps_pkg::SST_W-1:0] SST_LAST =
    ps_pkg::SST_W'(ps_pkg::SST_CYCLES - 1);

  ps_pkg::ps_pwr_type state_r;
  logic [ps_pkg::SST_W-1:0] sst_r;
  logic [ps_pkg::PHASE_W-1:0] phase_r;

  assign tim.phase = phase_r;
  assign tim.running = (state_r == ps_pkg::PWR_RUN);
  assign tim.cyc_end = tim.running && phase_r == ps_pkg::LAST_PHASE;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ps_pkg::PWR_START;
      sst_r <= '0;
    end else begin
      case (state_r)
        ps_pkg::PWR_START: begin
          sst_r <= sst_r + 1'b1;
          if (sst_r == SST_LAST) begin
            state_r <= ps_pkg::PWR_RUN;
          end
        end
        ps_pkg::PWR_RUN: begin
          if (tim.halt_req) begin
            state_r <= ps_pkg::PWR_HALT;
          end
        end
        ps_pkg::PWR_HALT: begin
          sst_r <= '0;
          if (wake_in) begin
            state_r <= ps_pkg::PWR_START;
          end
        end
        default: state_r <= ps_pkg::PWR_START;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_r <= '0;
    end else if (tim.running && !tim.halt_req) begin
      phase_r <= phase_r + 1'b1;
    end else begin
      phase_r <= '0;
    end
  end

  a_phase_wrap: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) tim.cyc_end && !tim.halt_req
    |=> phase_r == '0 ##3 tim.cyc_end)
    else $error("instruction cycle is not four clocks");
  a_startup_len: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) $rose(tim.running)
    |-> $past(sst_r) == SST_LAST)
    else $error("start-up period length wrong");
endmodule

// ==== rtl/ps_sequencer.sv ====
// Purpose: program counter, fetch pipeline, vectors and table reads
// Assumes: the decoder answers cmd_in for instr_out within the cycle
// Notes: cmd_in, skip and PCL writes are taken on the last phase only; table pointer writes on any clock
`timescale 1ns/1ps
module ps_sequencer (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // program memory
  output logic [ps_pkg::PC_W-1:0] pm_addr_out,
  input wire logic [ps_pkg::PM_W-1:0] pm_data_in,
  // decoder
  output logic [ps_pkg::PM_W-1:0] instr_out,
  output logic instr_valid_out,
  input wire ps_pkg::ps_cmd_type cmd_in,
  input wire logic skip_cond_in,
  input wire logic halt_in,
  input wire logic [ps_pkg::PC_W-1:0] target_in,
  // special registers
  input wire logic [ps_pkg::REG_AW-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [ps_pkg::DATA_W-1:0] reg_wdata_in,
  output logic [ps_pkg::DATA_W-1:0] reg_rdata_out,
  // table data
  output logic [ps_pkg::DATA_W-1:0] tbl_low_out,
  output logic tbl_low_valid_out,
  // interrupts
  input wire logic [ps_pkg::NUM_INT-1:0] int_req_in,
  input wire logic [ps_pkg::NUM_INT-1:0] int_en_in,
  output logic [ps_pkg::NUM_INT-1:0] int_pend_out,
  output logic [ps_pkg::NUM_INT-1:0] int_ack_out,
  output logic int_return_out,
  // power
  input wire logic wake_in,
  output logic running_out
);
  localparam int NI = ps_pkg::NUM_INT;
  localparam int PW = ps_pkg::PC_W;
  localparam int PL = ps_pkg::PAGE_LSB;

  ps_core_if core ();

  logic [PW-1:0] pc_r;
  logic [PW-1:0] pm_addr_r;
  logic [ps_pkg::PM_W-1:0] instr_r;
  logic [ps_pkg::PM_W-1:0] hold_r;
  logic valid_r;
  logic tbl_cyc_r;
  logic [ps_pkg::DATA_W-1:0] table_pointer_r;
  logic [ps_pkg::DATA_W-1:0] table_high_byte_r;
  logic [ps_pkg::DATA_W-1:0] tbl_low_r;
  logic tbl_low_vld_r;
  logic [ps_pkg::DATA_W-1:0] rdata_r;
  logic [NI-1:0] pend_r;
  logic [NI-1:0] ack_r;
  logic iret_r;
  logic run_r;

  ps_pkg::ps_cmd_type exec_cmd;
  logic pcl_wr;
  logic xfer;
  logic tbl_go;
  logic [PW-1:0] tgt;
  logic [PW-1:0] tbl_addr;
  logic [NI-1:0] cand;
  logic [NI-1:0] ack_vec;
  logic [PW-1:0] int_vec;
  logic [2:0] pc_page;

  ps_phase_gen u_phase (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .wake_in(wake_in),
    .tim(core.timing)
  );

  ps_return_stack #(
    .DEPTH(ps_pkg::STACK_DEPTH)
  ) u_stack (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .stk(core.stack)
  );

  assign pc_page = pc_r[PW-1:PL];
  assign exec_cmd = valid_r ? cmd_in : ps_pkg::CMD_NONE;
  assign pcl_wr = core.cyc_end && valid_r && reg_wr_in &&
    reg_addr_in == ps_pkg::PCL_OFS;

  assign tbl_addr = (exec_cmd == ps_pkg::CMD_TBL_LAST) ?
    {ps_pkg::LAST_PAGE, table_pointer_r} : {pc_page, table_pointer_r};

  assign cand = pend_r & int_en_in;
  assign ack_vec = (core.cyc_end && !tbl_cyc_r && !xfer && !tbl_go &&
    !core.halt_req && !core.full) ? (cand & (~cand + 1'b1)) : '0;

  always_comb begin
    int_vec = ps_pkg::RESET_VEC;
    for (int i = 0; i < NI; i++) begin
      if (ack_vec[i]) begin
        int_vec = ps_pkg::INT_VECS[i*PW +: PW];
      end
    end
  end

  always_comb begin
    xfer = 1'b0;
    tbl_go = 1'b0;
    tgt = pc_r;
    core.pop = 1'b0;
    if (core.cyc_end && !tbl_cyc_r) begin
      case (exec_cmd)
        ps_pkg::CMD_SKIP: begin
          if (skip_cond_in) begin
            xfer = 1'b1;
            tgt = pc_r + 1'b1;
          end
        end
        ps_pkg::CMD_JUMP, ps_pkg::CMD_CALL: begin
          xfer = 1'b1;
          tgt = target_in;
        end
        ps_pkg::CMD_RET, ps_pkg::CMD_RETURN_FROM_INTERRUPT: begin
          xfer = 1'b1;
          tgt = core.top_addr;
          core.pop = 1'b1;
        end
        ps_pkg::CMD_TBL_CUR, ps_pkg::CMD_TBL_LAST: begin
          tbl_go = 1'b1;
        end
        default: begin
        end
      endcase
      if (pcl_wr && !xfer && !tbl_go) begin
        xfer = 1'b1;
        tgt = {pc_page, reg_wdata_in};
      end
    end
  end

  assign core.push = (core.cyc_end && !tbl_cyc_r &&
    exec_cmd == ps_pkg::CMD_CALL) || (ack_vec != '0);
  assign core.push_addr = pc_r;
  assign core.halt_req = core.cyc_end && !tbl_cyc_r && valid_r &&
    halt_in && exec_cmd == ps_pkg::CMD_NONE && !pcl_wr;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_r <= ps_pkg::RESET_VEC;
      pm_addr_r <= ps_pkg::RESET_VEC;
      instr_r <= '0;
      hold_r <= '0;
      valid_r <= 1'b0;
      tbl_cyc_r <= 1'b0;
    end else if (core.cyc_end) begin
      if (tbl_cyc_r) begin
        instr_r <= hold_r;
        valid_r <= 1'b1;
        tbl_cyc_r <= 1'b0;
        pm_addr_r <= pc_r;
      end else if (xfer || ack_vec != '0) begin
        valid_r <= 1'b0;
        pc_r <= xfer ? tgt : int_vec;
        pm_addr_r <= xfer ? tgt : int_vec;
      end else if (tbl_go) begin
        hold_r <= pm_data_in;
        valid_r <= 1'b0;
        tbl_cyc_r <= 1'b1;
        pc_r <= pc_r + 1'b1;
        pm_addr_r <= tbl_addr;
      end else begin
        instr_r <= pm_data_in;
        valid_r <= 1'b1;
        pc_r <= pc_r + 1'b1;
        pm_addr_r <= pc_r + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      table_high_byte_r <= ps_pkg::TABLE_HIGH_BYTE_RST;
      tbl_low_r <= '0;
      tbl_low_vld_r <= 1'b0;
    end else begin
      tbl_low_vld_r <= core.cyc_end && tbl_cyc_r;
      if (core.cyc_end && tbl_cyc_r) begin
        tbl_low_r <= pm_data_in[PL-1:0];
        table_high_byte_r <= ps_pkg::DATA_W'(pm_data_in[ps_pkg::PM_W-1:PL]);
      end
    end
  end

  // table pointer writes and register reads
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      table_pointer_r <= ps_pkg::TABLE_POINTER_RST;
      rdata_r <= '0;
    end else begin
      if (reg_wr_in && reg_addr_in == ps_pkg::TABLE_POINTER_OFS) begin
        table_pointer_r <= reg_wdata_in;
      end
      case (reg_addr_in)
        ps_pkg::PCL_OFS: rdata_r <= pc_r[PL-1:0];
        ps_pkg::TABLE_POINTER_OFS: rdata_r <= table_pointer_r;
        ps_pkg::TABLE_HIGH_BYTE_OFS: rdata_r <= table_high_byte_r;
        default: rdata_r <= '0;
      endcase
    end
  end

  generate
    for (genvar g = 0; g < NI; g++) begin : g_pend
      always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pend_r[g] <= 1'b0;
        end else begin
          pend_r[g] <= int_req_in[g] | (pend_r[g] & ~ack_vec[g]);
        end
      end
    end
  endgenerate

  // status pulses and running flag
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_r <= '0;
      iret_r <= 1'b0;
      run_r <= 1'b0;
    end else begin
      ack_r <= ack_vec;
      iret_r <= core.pop && exec_cmd == ps_pkg::CMD_RETURN_FROM_INTERRUPT;
      run_r <= core.running;
    end
  end

  assign pm_addr_out = pm_addr_r;
  assign instr_out = instr_r;
  assign instr_valid_out = valid_r;
  assign reg_rdata_out = rdata_r;
  assign tbl_low_out = tbl_low_r;
  assign tbl_low_valid_out = tbl_low_vld_r;
  assign int_pend_out = pend_r;
  assign int_ack_out = ack_r;
  assign int_return_out = iret_r;
  assign running_out = run_r;

  a_pc_increment: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) core.cyc_end && !tbl_cyc_r && !xfer &&
    ack_vec == '0 |=> pc_r == $past(pc_r) + 11'h001)
    else $error("counter did not step by one");
  a_dummy_after_xfer: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) core.cyc_end && xfer |=> (!valid_r) [*3])
    else $error("no dummy cycle after transfer");
  a_skip_target: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) core.cyc_end && !tbl_cyc_r &&
    exec_cmd == ps_pkg::CMD_SKIP && skip_cond_in
    |=> pm_addr_r == $past(pc_r) + 11'h001 && !valid_r)
    else $error("skip target wrong");
  a_pcl_page: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) pcl_wr && exec_cmd == ps_pkg::CMD_NONE
    |=> pc_r == {$past(pc_page), $past(reg_wdata_in)})
    else $error("short jump left the page");
  a_ext_vector: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) ack_vec[0] |=> pm_addr_r == 11'h004)
    else $error("external vector wrong");
  a_tbl_last_page: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) tbl_go && exec_cmd == ps_pkg::CMD_TBL_LAST
    |=> pm_addr_r[PW-1:PL] == 3'h7 && tbl_cyc_r)
    else $error("last page table address wrong");
  a_tbl_two_cycles: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) tbl_go |-> ##5 tbl_low_vld_r && valid_r)
    else $error("table read not done in two cycles");
  a_int_order: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) ack_vec != '0 |-> $onehot(ack_vec) &&
    ((ack_vec - 4'h1) & cand) == '0 && !core.full)
    else $error("interrupt order or full stack broken");
endmodule

// ==== verification/ps_pm_model.sv ====
// Purpose: program memory seen by the sequencer
// Assumes: combinational read of the fetch address
// Notes: word pattern is address based, checked by the bench
`timescale 1ns/1ps
module ps_pm_model (
  // fetch port
  input wire logic [ps_pkg::PC_W-1:0] addr_in,
  output logic [ps_pkg::PM_W-1:0] data_out
);
  assign data_out = {addr_in[2:0] ^ 3'h5, addr_in};
endmodule

// ==== verification/tb.sv ====
// Purpose: self-checking bench of the program sequencer
// Assumes: commands issued once per instruction cycle
// Notes: a small model tracks fetch address and return stack
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); \
    end \
  end
module tb;
  logic core_clk_in, rst_n_in, skip_cond_in, halt_in, reg_wr_in;
  logic wake_in, instr_valid_out, tbl_low_valid_out, int_return_out;
  logic running_out;
  logic [10:0] pm_addr_out, target_in, epc, eia, tsv, twa;
  logic [13:0] pm_data_in, instr_out, tword;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, tbl_low_out;
  logic [7:0] wa, wd, tp, rdv, tlo;
  logic [3:0] int_req_in, int_en_in, int_pend_out, int_ack_out;
  logic [3:0] rq, en, pend, ack;
  logic sk, wr, ev, tfl;
  logic [10:0] stk[$];
  ps_pkg::ps_cmd_type cmd_in;
  int bad_count, checked, tcnt, rcnt;

  ps_sequencer dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .pm_addr_out(pm_addr_out), .pm_data_in(pm_data_in),
    .instr_out(instr_out), .instr_valid_out(instr_valid_out),
    .cmd_in(cmd_in), .skip_cond_in(skip_cond_in), .halt_in(halt_in),
    .target_in(target_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .tbl_low_out(tbl_low_out),
    .tbl_low_valid_out(tbl_low_valid_out), .int_req_in(int_req_in),
    .int_en_in(int_en_in), .int_pend_out(int_pend_out),
    .int_ack_out(int_ack_out), .int_return_out(int_return_out),
    .wake_in(wake_in), .running_out(running_out));
  ps_pm_model pm (.addr_in(pm_addr_out), .data_out(pm_data_in));

  function automatic logic [13:0] tw(input logic [10:0] a);
    return {a[2:0] ^ 3'h5, a};
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one instruction cycle: drive, check in the last phase, advance the model
  task automatic icyc(input ps_pkg::ps_cmd_type c, input logic [10:0] t);
    int k;
    k = 0;
    cmd_in <= c;
    target_in <= t;
    skip_cond_in <= sk;
    reg_wr_in <= wr;
    reg_addr_in <= wa;
    reg_wdata_in <= wd;
    int_req_in <= rq;
    int_en_in <= en;
    pend = pend | rq;
    @(posedge core_clk_in);
    int_req_in <= 4'h0;
    repeat (2) @(posedge core_clk_in);
    @(negedge core_clk_in);
    `CHK(pm_addr_out, epc);
    `CHK(instr_valid_out, ev);
    if (ev) `CHK(instr_out, tw(eia));
    `CHK(int_pend_out, pend);
    rdv = reg_rdata_out;
    @(posedge core_clk_in);
    if (wr && wa == 8'h07)
      tp = wd;
    if (tfl) begin
      eia = tsv;
      epc = tsv + 11'h1;
      ev = 1'b1;
      tfl = 1'b0;
    end else if (ev && c inside {ps_pkg::CMD_JUMP, ps_pkg::CMD_CALL}) begin
      stk.push_back(epc);
      if (c != ps_pkg::CMD_CALL)
        void'(stk.pop_back());
      if (stk.size() > 4)
        void'(stk.pop_front());
      epc = t;
      ev = 1'b0;
    end else if (ev && c inside {ps_pkg::CMD_RET, ps_pkg::CMD_RETURN_FROM_INTERRUPT}) begin
      epc = stk.pop_back();
      ev = 1'b0;
    end else if (ev && c == ps_pkg::CMD_SKIP && sk) begin
      epc = epc + 11'h1;
      ev = 1'b0;
    end else if (ev && c inside {ps_pkg::CMD_TBL_CUR,
                                 ps_pkg::CMD_TBL_LAST}) begin
      tsv = epc;
      epc = {(c == ps_pkg::CMD_TBL_LAST) ? 3'h7 : epc[10:8], tp};
      tword = tw(epc);
      ev = 1'b0;
      tfl = 1'b1;
    end else if (ev && wr && wa == 8'h06) begin
      epc = {epc[10:8], wd};
      ev = 1'b0;
    end else if ((pend & en) != 4'h0 && stk.size() < 4) begin
      while (!(pend[k] & en[k]))
        k++;
      stk.push_back(epc);
      epc = 11'(4 * (k + 1));
      pend[k] = 1'b0;
      ev = 1'b0;
    end else begin
      eia = epc;
      epc = epc + 11'h1;
      ev = 1'b1;
    end
    sk = 1'b0;
    wr = 1'b0;
    rq = 4'h0;
  endtask

  always @(negedge core_clk_in) begin
    if (tbl_low_valid_out === 1'b1) begin
      tlo = tbl_low_out;
      tcnt++;
    end
    if (int_ack_out !== 4'h0)
      ack = int_ack_out;
    if (int_return_out === 1'b1)
      rcnt++;
  end

  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end

  initial begin
    int i, j, n;
    {rst_n_in, skip_cond_in, halt_in, reg_wr_in, wake_in} = 5'h0;
    {sk, wr, ev, tfl, rq, en, pend, ack} = 20'h0;
    {target_in, reg_addr_in, reg_wdata_in, wa, wd, tp} = 51'h0;
    {int_req_in, int_en_in} = 8'h0;
    cmd_in = ps_pkg::CMD_NONE;
    {bad_count, checked, tcnt, rcnt} = 128'h0;
    repeat (8) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    reg_addr_in <= 8'h07;
    repeat (2) @(posedge core_clk_in);
    @(negedge core_clk_in);
    `CHK(reg_rdata_out, ps_pkg::TABLE_POINTER_RST);
    @(posedge core_clk_in);
    reg_addr_in <= 8'h08;
    repeat (2) @(posedge core_clk_in);
    @(negedge core_clk_in);
    `CHK(reg_rdata_out, ps_pkg::TABLE_HIGH_BYTE_RST);
    @(posedge core_clk_in);
    for (n = 6; n < 1100 && running_out !== 1'b1; n++)
      @(negedge core_clk_in);
    `CHK(n >= 1024 && n <= 1030, 1'b1);
    for (i = 0; i < 20 && instr_valid_out !== 1'b1; i++)
      @(negedge core_clk_in);
    if (i == 20) begin
      bad_count++;
      wrap_up();
    end
    `CHK(pm_addr_out, 11'h001);
    `CHK(instr_out, tw(11'h000));
    repeat (4) @(posedge core_clk_in);
    {epc, eia, ev} = {11'h002, 11'h001, 1'b1};
    icyc(ps_pkg::CMD_NONE, 11'h0);
    icyc(ps_pkg::CMD_JUMP, 11'h123);
    icyc(ps_pkg::CMD_NONE, 11'h0);
    sk = 1'b1;
    icyc(ps_pkg::CMD_SKIP, 11'h0);
    icyc(ps_pkg::CMD_NONE, 11'h0);
    icyc(ps_pkg::CMD_SKIP, 11'h0);
    {wr, wa, wd} = {1'b1, 8'h06, 8'h40};
    icyc(ps_pkg::CMD_NONE, 11'h0);
    {wr, wa, wd} = {1'b1, 8'h07, 8'h9a};
    icyc(ps_pkg::CMD_NONE, 11'h0);
    icyc(ps_pkg::CMD_NONE, 11'h0);
    `CHK(rdv, 8'h9a);
    wa = 8'h08;
    for (j = 0; j < 2; j++) begin
      icyc(j ? ps_pkg::CMD_TBL_LAST : ps_pkg::CMD_TBL_CUR, 11'h0);
      icyc(ps_pkg::CMD_NONE, 11'h0);
      icyc(ps_pkg::CMD_NONE, 11'h0);
      `CHK(tlo, tword[7:0]);
      `CHK(rdv, {2'h0, tword[13:8]});
      `CHK(tcnt, j + 1);
    end
    {wr, wd} = {1'b1, 8'hff};
    icyc(ps_pkg::CMD_NONE, 11'h0);
    icyc(ps_pkg::CMD_NONE, 11'h0);
    `CHK(rdv, {2'h0, tword[13:8]});
    wa = 8'h30;
    icyc(ps_pkg::CMD_NONE, 11'h0);
    `CHK(rdv, 8'h00);
    for (j = 0; j < 5; j++) begin
      icyc(ps_pkg::CMD_CALL, 11'h200 + 11'(j * 16));
      icyc(ps_pkg::CMD_NONE, 11'h0);
    end
    {rq, en} = 8'h11;
    icyc(ps_pkg::CMD_NONE, 11'h0);
    icyc(ps_pkg::CMD_NONE, 11'h0);
    icyc(ps_pkg::CMD_RET, 11'h0);
    icyc(ps_pkg::CMD_NONE, 11'h0);
    icyc(ps_pkg::CMD_NONE, 11'h0);
    `CHK(ack, 4'h1);
    en = 4'h0;
    icyc(ps_pkg::CMD_RETURN_FROM_INTERRUPT, 11'h0);
    icyc(ps_pkg::CMD_NONE, 11'h0);
    `CHK(rcnt, 1);
    for (j = 0; j < 3; j++) begin
      icyc(ps_pkg::CMD_RET, 11'h0);
      icyc(ps_pkg::CMD_NONE, 11'h0);
    end
    rq = 4'hf;
    icyc(ps_pkg::CMD_NONE, 11'h0);
    for (j = 0; j < 4; j++) begin
      en = 4'hf;
      icyc(ps_pkg::CMD_NONE, 11'h0);
      en = 4'h0;
      icyc(ps_pkg::CMD_NONE, 11'h0);
      icyc(ps_pkg::CMD_NONE, 11'h0);
      `CHK(ack, 4'(1 << j));
      icyc(ps_pkg::CMD_RETURN_FROM_INTERRUPT, 11'h0);
      icyc(ps_pkg::CMD_NONE, 11'h0);
    end
    `CHK(rcnt, 5);
    halt_in <= 1'b1;
    icyc(ps_pkg::CMD_NONE, 11'h0);
    halt_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    @(negedge core_clk_in);
    `CHK(running_out, 1'b0);
    @(posedge core_clk_in);
    wake_in <= 1'b1;
    for (n = 0; n < 1100 && running_out !== 1'b1; n++)
      @(negedge core_clk_in);
    `CHK(n >= 1024 && n <= 1030, 1'b1);
    wrap_up();
  end
endmodule
